// ==== inc/atc_pkg.sv ====
// Constants, register map and carrier types of the acquisition trigger control block.
// Assumes a single 25 MHz system clock and a plain address/strobe register port.
//
// Notes on behaviour
// - Start source selectable: function pins, trigger bus, counter, star line, internals.
// - Digital start source begins acquisition on the selected rising or falling edge.
// - Comparator start source always begins on its first rising edge.
// - Start trigger routed to pins or bus lines goes out as active-high pulse.
// - After reset every function pin is an input until software routes a trigger.
// - Pretriggered capture begins filling the buffer on the start trigger, often software.
// - Posttrigger sample count equals buffer size minus pretrigger count.
// - Reference detection is armed only after the pretrigger samples are captured.
// - A reference condition before the pretrigger count is reached is ignored.
// - With a full buffer the oldest sample is overwritten circularly.
// - After an accepted reference, store posttrigger samples, then stop.
// - Reference source selectable like start; stops on the selected edge.
// - Comparator reference source is recognised on its first rising edge.
// - Reference trigger routable to any function pin or trigger bus line.
// - Sample clock halts while pause is active and resumes when it goes inactive.
// - Pause has programmable active level and a selectable source.
// - Comparator pause source pauses on low or high level as configured.
// - Pause trigger routes out only to trigger bus lines.
// - Pause acts on source level only; edges have no effect.
// - Sample and conversion clocks are ignored until a valid start trigger.
// - End on sample count or reference in finite mode, stop command in continuous.
// - Without a trigger source, the software command acts as the start event.
package atc_pkg;

  // Register byte offsets.
  localparam logic [7:0] ATC_REG_CTRL    = 8'h00;
  localparam logic [7:0] ATC_REG_START   = 8'h04;
  localparam logic [7:0] ATC_REG_REF     = 8'h08;
  localparam logic [7:0] ATC_REG_PAUSE   = 8'h0C;
  localparam logic [7:0] ATC_REG_BUFSZ   = 8'h10;
  localparam logic [7:0] ATC_REG_PRETRIG = 8'h14;
  localparam logic [7:0] ATC_REG_DIV     = 8'h18;
  localparam logic [7:0] ATC_REG_FPROUTE = 8'h1C;
  localparam logic [7:0] ATC_REG_TBROUTE = 8'h20;
  localparam logic [7:0] ATC_REG_STATUS  = 8'h24;
  localparam logic [7:0] ATC_REG_WRPTR   = 8'h28;

  // Control register bit positions.
  localparam int ATC_CTL_ARM    = 0;
  localparam int ATC_CTL_STOP   = 1;
  localparam int ATC_CTL_FINITE = 2;
  localparam int ATC_CTL_REFEN  = 3;
  localparam int ATC_CTL_PSEN   = 4;

  // Trigger source register fields.
  localparam int ATC_SRC_LSB = 0;
  localparam int ATC_SRC_INV = 8;

  // Source codes.
  localparam logic [4:0] ATC_SRC_FP0  = 5'h00;
  localparam logic [4:0] ATC_SRC_TB0  = 5'h10;
  localparam logic [4:0] ATC_SRC_CTR  = 5'h18;
  localparam logic [4:0] ATC_SRC_STAR = 5'h19;
  localparam logic [4:0] ATC_SRC_CMP  = 5'h1A;
  localparam logic [4:0] ATC_SRC_SW   = 5'h1B;
  localparam int         ATC_NSRC     = 27;

  // Widths and reset values.
  localparam int          ATC_NFP       = 16;
  localparam int          ATC_NTB       = 8;
  localparam int          ATC_CW        = 16;
  localparam logic [15:0] ATC_BUFSZ_RST = 16'h0010;
  localparam logic [15:0] ATC_PRE_RST   = 16'h0004;
  localparam logic [15:0] ATC_DIV_RST   = 16'h0018;

  // One trigger's source and polarity.
  typedef struct packed {
    logic       inv;
    logic [4:0] src;
  } atc_trig_cfg_t;

  // Synchronised trigger inputs.
  typedef struct packed {
    logic                cmp;
    logic                star;
    logic                ctr;
    logic [ATC_NTB-1:0]  tb;
    logic [ATC_NFP-1:0]  fp;
  } atc_inputs_t;

endpackage

// ==== core/atc_trigger_ctrl.sv ====
// Acquisition trigger control: start, reference and pause triggers, sample pacing,
// circular buffer addressing and trigger routing back to pins.
// Assumes inputs may be asynchronous and a register master that never waits.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module atc_trigger_ctrl
  import atc_pkg::*;
(
  input  wire logic                CLK_SYS_I,
  input  wire logic                NRST_I,
  input  wire logic [7:0]          ADDR_I,
  input  wire logic [31:0]         WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [31:0]         RDATA_O,
  input  wire logic [ATC_NFP-1:0]  FP_I,
  input  wire logic [ATC_NTB-1:0]  TB_I,
  input  wire logic                CTR_I,
  input  wire logic                STAR_I,
  input  wire logic                CMP_I,
  output logic      [ATC_NFP-1:0]  FP_O,
  output logic      [ATC_NFP-1:0]  FP_OE_O,
  output logic      [ATC_NTB-1:0]  TB_O,
  output logic      [ATC_NTB-1:0]  TB_OE_O,
  output logic                     SMP_STB_O,
  output logic      [ATC_CW-1:0]   SMP_ADDR_O,
  output logic                     RUN_O,
  output logic                     DONE_O
);

  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_ACQ, ST_POST, ST_DONE} atc_state_t;

  // Picks one synchronised input by source code; codes past the table read low.
  function automatic logic atc_pick(input logic [4:0] sel, input atc_inputs_t v);
    logic [ATC_NSRC-1:0] flat;
    flat = v;
    atc_pick = (int'(sel) < ATC_NSRC) ? flat[sel] : 1'b0;
  endfunction

  atc_state_t          state_r;
  atc_trig_cfg_t       start_cfg_r;
  atc_trig_cfg_t       ref_cfg_r;
  atc_trig_cfg_t       pause_cfg_r;
  logic                finite_r;
  logic                ref_en_r;
  logic                pause_en_r;
  logic [ATC_CW-1:0]   bufsz_r;
  logic [ATC_CW-1:0]   pretrig_r;
  logic [ATC_CW-1:0]   div_r;
  logic [31:0]         fp_route_r;
  logic [23:0]         tb_route_r;
  atc_inputs_t         sync1_r;
  atc_inputs_t         sync2_r;
  logic                start_prev_r;
  logic                ref_prev_r;
  logic [ATC_CW-1:0]   div_cnt_r;
  logic [ATC_CW-1:0]   wr_ptr_r;
  logic [ATC_CW-1:0]   pre_cnt_r;
  logic [ATC_CW-1:0]   post_cnt_r;
  logic [ATC_CW-1:0]   smp_cnt_r;
  logic                paused_r;
  logic                arm_cmd;
  logic                stop_cmd;
  logic                start_lvl;
  logic                ref_lvl;
  logic                start_evt;
  logic                ref_evt;
  logic                ref_armed;
  logic                running;
  logic                smp_tick;
  logic                start_acc;
  logic                ref_acc;
  logic [ATC_CW-1:0]   post_target;

  // Command pulses from control register writes.
  assign arm_cmd  = WR_I && (ADDR_I == ATC_REG_CTRL) && WDATA_I[ATC_CTL_ARM];
  assign stop_cmd = WR_I && (ADDR_I == ATC_REG_CTRL) && WDATA_I[ATC_CTL_STOP];

  // Configuration registers; trigger pins all start as inputs.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      start_cfg_r <= '{inv: 1'b0, src: ATC_SRC_SW};
      ref_cfg_r   <= '{inv: 1'b0, src: ATC_SRC_FP0};
      pause_cfg_r <= '{inv: 1'b0, src: ATC_SRC_FP0};
      finite_r    <= 1'b1;
      ref_en_r    <= 1'b0;
      pause_en_r  <= 1'b0;
      bufsz_r     <= ATC_BUFSZ_RST;
      pretrig_r   <= ATC_PRE_RST;
      div_r       <= ATC_DIV_RST;
      fp_route_r  <= 32'h0000_0000;
      tb_route_r  <= 24'h00_0000;
    end else if (WR_I) begin
      case (ADDR_I)
        ATC_REG_CTRL: begin
          finite_r   <= WDATA_I[ATC_CTL_FINITE];
          ref_en_r   <= WDATA_I[ATC_CTL_REFEN];
          pause_en_r <= WDATA_I[ATC_CTL_PSEN];
        end
        ATC_REG_START:   start_cfg_r <= '{inv: WDATA_I[ATC_SRC_INV], src: WDATA_I[ATC_SRC_LSB +: 5]};
        ATC_REG_REF:     ref_cfg_r   <= '{inv: WDATA_I[ATC_SRC_INV], src: WDATA_I[ATC_SRC_LSB +: 5]};
        ATC_REG_PAUSE:   pause_cfg_r <= '{inv: WDATA_I[ATC_SRC_INV], src: WDATA_I[ATC_SRC_LSB +: 5]};
        ATC_REG_BUFSZ:   bufsz_r     <= WDATA_I[ATC_CW-1:0];
        ATC_REG_PRETRIG: pretrig_r   <= WDATA_I[ATC_CW-1:0];
        ATC_REG_DIV:     div_r       <= WDATA_I[ATC_CW-1:0];
        ATC_REG_FPROUTE: fp_route_r  <= WDATA_I;
        ATC_REG_TBROUTE: tb_route_r  <= WDATA_I[23:0];
        default: begin
        end
      endcase
    end
  end

  // Two-stage synchroniser on every external trigger input.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= '{cmp: CMP_I, star: STAR_I, ctr: CTR_I, tb: TB_I, fp: FP_I};
      sync2_r <= sync1_r;
    end
  end

  // Selected trigger levels; the comparator ignores the edge choice.
  assign start_lvl = atc_pick(start_cfg_r.src, sync2_r);
  assign ref_lvl   = atc_pick(ref_cfg_r.src, sync2_r);

  // Previous selected levels for edge detection.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      start_prev_r <= 1'b0;
      ref_prev_r   <= 1'b0;
    end else begin
      start_prev_r <= start_lvl;
      ref_prev_r   <= ref_lvl;
    end
  end

  // Start event: software code starts at once, comparator on rise, else selected edge.
  always_comb begin
    if (start_cfg_r.src == ATC_SRC_SW) begin
      start_evt = 1'b1;
    end else if (start_cfg_r.src == ATC_SRC_CMP) begin
      start_evt = start_lvl && !start_prev_r;
    end else if (start_cfg_r.inv) begin
      start_evt = !start_lvl && start_prev_r;
    end else begin
      start_evt = start_lvl && !start_prev_r;
    end
  end

  // Reference event on the selected edge, comparator always on its rise.
  always_comb begin
    if (ref_cfg_r.src == ATC_SRC_CMP) begin
      ref_evt = ref_lvl && !ref_prev_r;
    end else if (ref_cfg_r.inv) begin
      ref_evt = !ref_lvl && ref_prev_r;
    end else begin
      ref_evt = ref_lvl && !ref_prev_r;
    end
  end

  // Pause follows the source level only, with programmable active level.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      paused_r <= 1'b0;
    end else begin
      paused_r <= pause_en_r && (atc_pick(pause_cfg_r.src, sync2_r) ^ pause_cfg_r.inv);
    end
  end

  assign running     = (state_r == ST_ACQ) || (state_r == ST_POST);
  assign post_target = bufsz_r - pretrig_r;
  assign ref_armed   = (pre_cnt_r >= pretrig_r);
  assign start_acc   = (state_r == ST_ARMED) && start_evt && !stop_cmd;
  assign ref_acc     = (state_r == ST_ACQ) && finite_r && ref_en_r && ref_evt && ref_armed && !stop_cmd;

  // Sample clock divider: stands still outside an acquisition and while paused.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_cnt_r <= 16'h0000;
    end else if (!running) begin
      div_cnt_r <= 16'h0000;
    end else if (!paused_r) begin
      div_cnt_r <= (div_cnt_r >= div_r) ? 16'h0000 : div_cnt_r + 16'h0001;
    end
  end

  assign smp_tick = running && !paused_r && (div_cnt_r >= div_r);

  // Acquisition sequencer.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= ST_IDLE;
    end else if (stop_cmd) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE, ST_DONE: begin
          if (arm_cmd) begin
            state_r <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (start_acc) begin
            state_r <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (ref_acc) begin
            state_r <= ST_POST;
          end else if (finite_r && !ref_en_r && smp_tick && (smp_cnt_r + 16'h0001 >= bufsz_r)) begin
            state_r <= ST_DONE;
          end
        end
        ST_POST: begin
          if (smp_tick && (post_cnt_r + 16'h0001 >= post_target)) begin
            state_r <= ST_DONE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Buffer pointer and sample counters.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_ptr_r   <= 16'h0000;
      pre_cnt_r  <= 16'h0000;
      post_cnt_r <= 16'h0000;
      smp_cnt_r  <= 16'h0000;
    end else if (start_acc) begin
      wr_ptr_r   <= 16'h0000;
      pre_cnt_r  <= 16'h0000;
      post_cnt_r <= 16'h0000;
      smp_cnt_r  <= 16'h0000;
    end else if (smp_tick) begin
      wr_ptr_r  <= (wr_ptr_r + 16'h0001 >= bufsz_r) ? 16'h0000 : wr_ptr_r + 16'h0001;
      smp_cnt_r <= smp_cnt_r + 16'h0001;
      if (state_r == ST_ACQ && !ref_armed) begin
        pre_cnt_r <= pre_cnt_r + 16'h0001;
      end
      if (state_r == ST_POST) begin
        post_cnt_r <= post_cnt_r + 16'h0001;
      end
    end
  end

  // Sample strobe, buffer address and run flags.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SMP_STB_O  <= 1'b0;
      SMP_ADDR_O <= 16'h0000;
      RUN_O      <= 1'b0;
      DONE_O     <= 1'b0;
    end else begin
      SMP_STB_O  <= smp_tick;
      SMP_ADDR_O <= wr_ptr_r;
      RUN_O      <= running;
      DONE_O     <= (state_r == ST_DONE);
    end
  end

  // Trigger routing: start and reference pulse out, pause level to bus lines only.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FP_O    <= 16'h0000;
      FP_OE_O <= 16'h0000;
      TB_O    <= 8'h00;
      TB_OE_O <= 8'h00;
    end else begin
      FP_O    <= ({ATC_NFP{start_acc}} & fp_route_r[15:0]) | ({ATC_NFP{ref_acc}} & fp_route_r[31:16]);
      FP_OE_O <= fp_route_r[15:0] | fp_route_r[31:16];
      TB_O    <= ({ATC_NTB{start_acc}} & tb_route_r[7:0]) | ({ATC_NTB{ref_acc}} & tb_route_r[15:8])
               | ({ATC_NTB{paused_r}} & tb_route_r[23:16]);
      TB_OE_O <= tb_route_r[7:0] | tb_route_r[15:8] | tb_route_r[23:16];
    end
  end

  // Read data one cycle after the read strobe; unmapped offsets read zero.
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      case (ADDR_I)
        ATC_REG_CTRL:    RDATA_O <= {27'h0, pause_en_r, ref_en_r, finite_r, 2'b00};
        ATC_REG_START:   RDATA_O <= {23'h0, start_cfg_r.inv, 3'b000, start_cfg_r.src};
        ATC_REG_REF:     RDATA_O <= {23'h0, ref_cfg_r.inv, 3'b000, ref_cfg_r.src};
        ATC_REG_PAUSE:   RDATA_O <= {23'h0, pause_cfg_r.inv, 3'b000, pause_cfg_r.src};
        ATC_REG_BUFSZ:   RDATA_O <= {16'h0, bufsz_r};
        ATC_REG_PRETRIG: RDATA_O <= {16'h0, pretrig_r};
        ATC_REG_DIV:     RDATA_O <= {16'h0, div_r};
        ATC_REG_FPROUTE: RDATA_O <= fp_route_r;
        ATC_REG_TBROUTE: RDATA_O <= {8'h0, tb_route_r};
        ATC_REG_STATUS:  RDATA_O <= {26'h0, paused_r, ref_armed, state_r == ST_DONE, state_r == ST_POST,
                                     running, state_r == ST_ARMED};
        ATC_REG_WRPTR:   RDATA_O <= {post_cnt_r, wr_ptr_r};
        default:         RDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  // Checks kept beside the logic.
  property p_arm_hold;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (state_r == ST_ARMED && !start_evt && !stop_cmd) |=> (state_r == ST_ARMED);
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("Left armed state without a start event.");

  property p_cmp_start_rise;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (state_r == ST_ARMED && start_cfg_r.src == ATC_SRC_CMP && !stop_cmd && sync2_r.cmp && !$past(sync2_r.cmp))
      |=> (state_r == ST_ACQ);
  endproperty
  a_cmp_start_rise: assert property (p_cmp_start_rise) else $error("Comparator rise did not start.");

  property p_no_tick_idle;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    !running |-> ##1 !SMP_STB_O;
  endproperty
  a_no_tick_idle: assert property (p_no_tick_idle) else $error("Sample strobe outside acquisition.");

  property p_pause_gate;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    paused_r [*2] |-> ##1 !SMP_STB_O;
  endproperty
  a_pause_gate: assert property (p_pause_gate) else $error("Sample strobe while paused.");

  property p_ref_ignored;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (state_r == ST_ACQ && ref_evt && !ref_armed && !stop_cmd) |=> (state_r != ST_POST);
  endproperty
  a_ref_ignored: assert property (p_ref_ignored) else $error("Early reference was accepted.");

  property p_ref_accept;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (state_r == ST_ACQ && finite_r && ref_en_r && ref_evt && (pre_cnt_r >= pretrig_r) && !stop_cmd)
      |=> (state_r == ST_POST) && (post_cnt_r == 16'h0000);
  endproperty
  a_ref_accept: assert property (p_ref_accept) else $error("Armed reference not accepted.");

  property p_post_end;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (state_r == ST_POST && smp_tick && !stop_cmd && post_cnt_r == bufsz_r - pretrig_r - 16'h0001)
      |=> (state_r == ST_DONE) ##1 DONE_O;
  endproperty
  a_post_end: assert property (p_post_end) else $error("Capture did not stop after posttrigger count.");

  property p_wrap;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (smp_tick && !start_acc && wr_ptr_r == bufsz_r - 16'h0001) |=> (wr_ptr_r == 16'h0000) ##1 (SMP_ADDR_O == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Write pointer did not wrap.");

  property p_start_pulse;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    start_acc |=> ((FP_O & $past(fp_route_r[15:0])) == $past(fp_route_r[15:0]));
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("Start pulse missing on routed pins.");

  property p_pins_input;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
    (fp_route_r == 32'h0000_0000) |=> (FP_OE_O == 16'h0000);
  endproperty
  a_pins_input: assert property (p_pins_input) else $error("Function pin driven without routing.");

endmodule

// ==== test/atc_trig_src.sv ====
// Partner model: the outside trigger sources seen by the trigger control block.
// Assumes one source is active at a time and that idle sources and undriven pins sit low.
`timescale 1ns/100ps
module atc_trig_src
  import atc_pkg::*;
(
  input  wire logic [4:0]         sel_i,
  input  wire logic               lvl_i,
  input  wire logic [ATC_NFP-1:0] fp_out_i,
  input  wire logic [ATC_NFP-1:0] fp_oe_i,
  input  wire logic [ATC_NTB-1:0] tb_out_i,
  input  wire logic [ATC_NTB-1:0] tb_oe_i,
  output logic      [ATC_NFP-1:0] fp_o,
  output logic      [ATC_NTB-1:0] tb_o,
  output logic                    ctr_o,
  output logic                    star_o,
  output logic                    cmp_o
);
  logic [ATC_NFP-1:0] src_fp;
  logic [ATC_NTB-1:0] src_tb;

  // Drives the selected source and resolves each shared wire from the block's output enables.
  always_comb begin
    src_fp = '0;
    src_tb = '0;
    if (lvl_i && sel_i < ATC_SRC_TB0) begin
      src_fp[sel_i[3:0]] = 1'b1;
    end
    if (lvl_i && sel_i >= ATC_SRC_TB0 && sel_i < ATC_SRC_CTR) begin
      src_tb[sel_i[2:0]] = 1'b1;
    end
    fp_o   = (fp_oe_i & fp_out_i) | (~fp_oe_i & src_fp);
    tb_o   = (tb_oe_i & tb_out_i) | (~tb_oe_i & src_tb);
    ctr_o  = lvl_i && sel_i == ATC_SRC_CTR;
    star_o = lvl_i && sel_i == ATC_SRC_STAR;
    cmp_o  = lvl_i && sel_i == ATC_SRC_CMP;
  end
endmodule

// ==== test/tb_top.sv ====
// Testbench: drives registers and trigger sources, checks pacing, addressing and routing.
// Assumes the partner model in atc_trig_src and the register map of the package.
`timescale 1ns/100ps
module tb_top
  import atc_pkg::*;
;
  logic               clk_sys, nrst, wr_s, rd_s, ctr, star, cmp, smp_stb, run, done, lvl;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata;
  logic [ATC_NFP-1:0] fp_i, fp_o, fp_oe, fp_seen;
  logic [ATC_NTB-1:0] tb_i, tb_o, tb_oe, tb_seen;
  logic [ATC_CW-1:0]  smp_addr, exp_addr, bufsz;
  logic [4:0]         sel;
  int                 err_count, comparisons, smp_cnt;

  atc_trigger_ctrl atc_trigger_ctrl_inst (.CLK_SYS_I(clk_sys), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .FP_I(fp_i), .TB_I(tb_i), .CTR_I(ctr), .STAR_I(star),
    .CMP_I(cmp), .FP_O(fp_o), .FP_OE_O(fp_oe), .TB_O(tb_o), .TB_OE_O(tb_oe), .SMP_STB_O(smp_stb),
    .SMP_ADDR_O(smp_addr), .RUN_O(run), .DONE_O(done));
  atc_trig_src atc_trig_src_inst (.sel_i(sel), .lvl_i(lvl), .fp_out_i(fp_o), .fp_oe_i(fp_oe),
    .tb_out_i(tb_o), .tb_oe_i(tb_oe), .fp_o(fp_i), .tb_o(tb_i), .ctr_o(ctr), .star_o(star), .cmp_o(cmp));

  // Clock of 40 ns period.
  always #20 clk_sys = ~clk_sys;

  // Compares a seen value with its expectation and counts both.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Watches strobes: addresses must run round the buffer; routed pulses are remembered.
  always @(posedge clk_sys) begin
    if (smp_stb === 1'b1) begin
      chk(smp_addr, exp_addr);
      exp_addr = (exp_addr + 16'h0001) % bufsz;
      smp_cnt++;
    end
    fp_seen = fp_seen | fp_o;
    tb_seen = tb_seen | tb_o;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Clears the per-window counts; the expected address follows the run and restarts only at arming.
  task automatic clr;
    smp_cnt  = 0;
    fp_seen  = '0;
    tb_seen  = '0;
  endtask

  // One-cycle write; the strobe is lowered at the edge that takes it.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_sys);
    wr_s  <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic cfg(input logic [31:0] start, input logic [15:0] bsz, input logic [15:0] pre,
                     input logic [15:0] div);
    reg_wr(ATC_REG_START, start);
    reg_wr(ATC_REG_BUFSZ, {16'h0000, bsz});
    reg_wr(ATC_REG_PRETRIG, {16'h0000, pre});
    reg_wr(ATC_REG_DIV, {16'h0000, div});
    bufsz = bsz;
  endtask

  task automatic arm(input logic [31:0] ctl);
    reg_wr(ATC_REG_CTRL, ctl | 32'h0000_0001);
    #1;
    exp_addr = '0;
    clr();
  endtask

  task automatic stop;
    reg_wr(ATC_REG_CTRL, 32'h0000_0002);
    cyc(3);
    chk(run, 1'b0);
    sel <= 5'h1F;
    lvl <= 1'b0;
  endtask

  task automatic wait_done;
    for (int i = 0; i < 1000 && done !== 1'b1; i++) @(posedge clk_sys);
    cyc(3);
  endtask

  task automatic t_reset;
    chk(fp_oe, 16'h0000);
    chk(smp_cnt, 0);
    reg_rd(ATC_REG_CTRL, 32'h0000_0004);
    reg_rd(ATC_REG_START, {27'h0, ATC_SRC_SW});
    reg_rd(ATC_REG_BUFSZ, {16'h0, ATC_BUFSZ_RST});
    reg_rd(ATC_REG_PRETRIG, {16'h0, ATC_PRE_RST});
    reg_rd(ATC_REG_DIV, {16'h0, ATC_DIV_RST});
    reg_wr(ATC_REG_STATUS, 32'hFFFF_FFFF);
    reg_rd(ATC_REG_STATUS, 32'h0000_0000);
    reg_rd(8'h30, 32'h0000_0000);
    $display("reset test finished");
  endtask

  task automatic t_sw_start;
    cfg({27'h0, ATC_SRC_SW}, 16'h0008, 16'h0002, 16'h0003);
    reg_wr(ATC_REG_FPROUTE, 32'h0000_0008);
    reg_wr(ATC_REG_TBROUTE, 32'h0000_0001);
    cyc(1);
    chk(fp_oe, 16'h0008);
    arm(32'h0000_0004);
    wait_done();
    chk(smp_cnt, 8);
    chk(fp_seen, 16'h0008);
    chk(tb_seen, 8'h01);
    reg_rd(ATC_REG_STATUS, 32'h0000_0018);
    stop();
    reg_wr(ATC_REG_FPROUTE, 32'h0000_0000);
    reg_wr(ATC_REG_TBROUTE, 32'h0000_0000);
    $display("software start test finished");
  endtask

  // Every kind of start source except software, with rising and falling edges.
  task automatic t_edge;
    logic [4:0] codes [6] = '{5'h05, 5'h05, 5'h12, ATC_SRC_CTR, ATC_SRC_STAR, ATC_SRC_CMP};
    logic       invs  [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 6; k++) begin
      cfg({23'h0, invs[k], 3'h0, codes[k]}, 16'h0010, 16'h0004, 16'h0009);
      sel <= codes[k];
      lvl <= 1'b0;
      arm(32'h0000_0004);
      cyc(8);
      chk(run, 1'b0);
      chk(smp_cnt, 0);
      lvl <= 1'b1;
      cyc(8);
      chk(run, !invs[k] || codes[k] == ATC_SRC_CMP);
      lvl <= 1'b0;
      cyc(8);
      chk(run, 1'b1);
      stop();
    end
    $display("start edge test finished");
  endtask

  task automatic t_ref;
    cfg({27'h0, ATC_SRC_SW}, 16'h0008, 16'h0003, 16'h0009);
    reg_wr(ATC_REG_REF, 32'h0000_0007);
    reg_wr(ATC_REG_TBROUTE, 32'h0000_0200);
    sel <= 5'h07;
    arm(32'h0000_000C);
    lvl <= 1'b1;
    cyc(6);
    lvl <= 1'b0;
    for (int i = 0; i < 400 && smp_cnt < 12; i++) @(posedge clk_sys);
    cyc(1);
    chk(done, 1'b0);
    chk(tb_seen, 8'h00);
    for (int i = 0; i < 20 && smp_stb !== 1'b1; i++) @(posedge clk_sys);
    #1;
    lvl <= 1'b1;
    smp_cnt = 0;
    wait_done();
    chk(done, 1'b1);
    chk(smp_cnt, 5);
    chk(tb_seen, 8'h02);
    stop();
    $display("reference test finished");
  endtask

  task automatic t_pause;
    cfg({27'h0, ATC_SRC_SW}, 16'h0008, 16'h0002, 16'h0003);
    reg_wr(ATC_REG_PAUSE, 32'h0000_0009);
    reg_wr(ATC_REG_TBROUTE, 32'h0010_0000);
    sel <= 5'h09;
    lvl <= 1'b1;
    arm(32'h0000_0010);
    cyc(10);
    clr();
    cyc(40);
    chk(smp_cnt, 0);
    chk(tb_o[4], 1'b1);
    chk(tb_oe, 8'h10);
    chk(fp_oe, 16'h0000);
    lvl <= 1'b0;
    cyc(6);
    clr();
    cyc(40);
    chk(smp_cnt, 10);
    reg_wr(ATC_REG_PAUSE, 32'h0000_011A);
    sel <= ATC_SRC_CMP;
    cyc(10);
    clr();
    cyc(40);
    chk(smp_cnt, 0);
    lvl <= 1'b1;
    cyc(6);
    clr();
    cyc(40);
    chk(smp_cnt, 10);
    stop();
    $display("pause test finished");
  endtask

  task automatic test_done;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the under one thousand cycles the tests need.
  initial begin
    #(40 * 20000);
    err_count++;
    $display("watchdog expired");
    test_done();
  end

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    clk_sys     = 1'b0;
    nrst        = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0000_0000;
    wr_s        = 1'b0;
    rd_s        = 1'b0;
    sel         = 5'h1F;
    lvl         = 1'b0;
    bufsz       = 16'h0010;
    err_count   = 0;
    comparisons = 0;
    exp_addr    = '0;
    clr();
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(2);
    t_reset();
    t_sw_start();
    t_edge();
    t_ref();
    t_pause();
    test_done();
  end
endmodule
